// File: hdl/ela_pkg.sv
package ela_pkg;
	// Bus geometry
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	// Register byte offsets
	localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFS_LOOP_SLOT = 8'h04;
	localparam logic [APB_AW-1:0] OFS_IDLE_CODE = 8'h08;
	localparam logic [APB_AW-1:0] OFS_ERR_INS = 8'h0c;
	localparam logic [APB_AW-1:0] OFS_INT_STAT = 8'h10;
	localparam logic [APB_AW-1:0] OFS_ALARM = 8'h14;
	localparam logic [APB_AW-1:0] OFS_CNT_BASE = 8'h18;
	localparam int CNT_NUM = 6;
	localparam int CNT_W = 16;
	// Counter indices
	localparam int CNT_FRAME = 0;
	localparam int CNT_CODE = 1;
	localparam int CNT_CRC4 = 2;
	localparam int CNT_EBIT = 3;
	localparam int CNT_TWO = 4;
	localparam int CNT_THREE = 5;
	// Control register layout, bit 0 is payload loop
	typedef struct packed {
		logic cas_mode;
		logic crc4_mode;
		logic chan_loop_en;
		logic alarm_simulation_enable;
		logic transmit_ais_enable;
		logic local_loop_enable;
		logic transparent_slot0_enable;
		logic send_ais_to_system;
		logic payload_loop_enable;
	} ela_ctrl_t;
	localparam int CTRL_W = 9;
	localparam ela_ctrl_t CTRL_RST = 9'h000;
	// Error insertion request bits
	localparam int INS_FAS = 0;
	localparam int INS_MF = 1;
	localparam int INS_CRC = 2;
	localparam int INS_CAS = 3;
	localparam int INS_PRBS = 4;
	localparam int INS_BPV = 5;
	localparam int INS_W = 6;
	// Alarms: los, ais, lof, rai; events: rx slip, tx slip
	localparam int ALM_W = 4;
	localparam int ISR_W = 6;
	localparam int SLIP_W = 2;
	// Frame geometry
	localparam int POS_W = 8;
	localparam int SLOT_W = 5;
	localparam int MFRM_W = 4;
	localparam int FRAME_BITS = 256;
	localparam logic [SLOT_W-1:0] SLOT_FRAME = 5'h00;
	localparam logic [SLOT_W-1:0] SLOT_SIG = 5'h10;
	localparam logic [SLOT_W-1:0] SLOT_PRBS = 5'h01;
	localparam logic [6:0] FAS_WORD = 7'h1b;
	// Simulated events: one per frame time
	localparam int CLK_PS = 5000;
	localparam int FRAME_PS = 125000000;
	localparam int FRAME_CYC = FRAME_PS / CLK_PS;
	localparam int TICK_W = 16;
endpackage

// File: hdl/ela_loop_test.sv
`timescale 1ns/1ps
// Overview of operation
// [RL1] Payload loop: received data through store to transmitter
// [RL2] Payload loop may send AIS to system side
// [RL3] Slot zero generated locally unless transparent
// [RL4] Transparent slot zero loops received slot zero
// [RL5] Payload loop clocks transmitter from receive clock
// [RL6] Payload loop ignores transmit system pins
// [RL7] Local loop feeds transmit data into receiver
// [RL8] Local loop still transmits system stream on line
// [RL9] Transmit AIS leaves locally looped data intact
// [RL10] Local loop loses framing; line codes must match
// [RL11] One selected slot looped system in to out
// [RL12] Looped slot sends idle code to remote
// [RL13] System uses quasi-static pattern for slot test
// [RL14] Simulation hides real alarms, traffic continues
// [RL15] Simulation raises alarms, slips and mode-applicable counters
// [RL16] Only mode-applicable indications are simulated
// [RL17] Simulation sets status bits, counts while set
// [RL18] Sim off drops simulated alarms; statuses stay pending
// [RL19] Status and counters clear when read
// [RL20] Insert single defects of six kinds
// [RL21] Each request inserts exactly one defect
module ela_loop_test
	import ela_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ela_pkg::APB_AW-1:0] paddr,
	input wire logic [ela_pkg::APB_DW-1:0] pwdata,
	output logic [ela_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive system side pins
	input wire logic receive_system_clock,
	input wire logic receive_sync_pulse,
	output logic receive_system_data_out,
	// Transmit system side pins
	input wire logic transmit_system_clock,
	input wire logic transmit_system_data_in,
	input wire logic transmit_signaling_in,
	input wire logic transmit_sync_pulse,
	input wire logic transmit_multiframe_sync,
	// Line side, single rail
	input wire logic line_receive_inputs,
	output logic line_transmit_outputs,
	output logic line_bpv_insert,
	// Real conditions from the framer core
	input wire logic [ela_pkg::ALM_W-1:0] real_alarm,
	input wire logic [ela_pkg::SLIP_W-1:0] real_slip,
	input wire logic [ela_pkg::CNT_NUM-1:0] real_err
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	localparam int PIN_N = 8;
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_meta_ff;
	logic [PIN_N-1:0] pin_s_ff;
	logic rxc_d_ff;
	logic txc_d_ff;
	assign pin_raw = {receive_system_clock, receive_sync_pulse,
		transmit_system_clock, transmit_system_data_in,
		transmit_signaling_in, transmit_sync_pulse,
		transmit_multiframe_sync, line_receive_inputs};
	// Two flops per pin, then clock edge history
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_meta_ff <= '0;
			pin_s_ff <= '0;
			rxc_d_ff <= 1'b0;
			txc_d_ff <= 1'b0;
		end
		else
		begin
			pin_meta_ff <= pin_raw;
			pin_s_ff <= pin_meta_ff;
			rxc_d_ff <= pin_s_ff[7];
			txc_d_ff <= pin_s_ff[5];
		end
	end
	wire rxc_s = pin_s_ff[7];
	wire rx_sync_s = pin_s_ff[6];
	wire txc_s = pin_s_ff[5];
	wire tx_data_s = pin_s_ff[4];
	wire tx_sig_s = pin_s_ff[3];
	wire tx_sync_s = pin_s_ff[2];
	wire tx_mfs_s = pin_s_ff[1];
	wire line_rx_s = pin_s_ff[0];
	wire rx_stb = rxc_s & ~rxc_d_ff;
	wire txc_rise = txc_s & ~txc_d_ff;

	////////////////////////////////////////////////////////////////////
	// Register state
	ela_ctrl_t ctrl_ff;
	logic [SLOT_W-1:0] loop_slot_ff;
	logic [7:0] idle_code_ff;
	logic [INS_W-1:0] ins_pend_ff;
	logic [ISR_W-1:0] isr_ff;
	logic [ALM_W-1:0] alm_prev_ff;
	logic [CNT_NUM-1:0][CNT_W-1:0] cnt_ff;
	logic [APB_DW-1:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	wire plb = ctrl_ff.payload_loop_enable;
	wire sim = ctrl_ff.alarm_simulation_enable;

	// Bus decode
	wire apb_setup = psel & ~penable;
	wire apb_done = psel & penable & pready_ff;
	wire wr_done = apb_done & pwrite;
	wire rd_done = apb_done & ~pwrite;
	wire hit_ctrl = paddr == OFS_CTRL;
	wire hit_slot = paddr == OFS_LOOP_SLOT;
	wire hit_idle = paddr == OFS_IDLE_CODE;
	wire hit_ins = paddr == OFS_ERR_INS;
	wire hit_isr = paddr == OFS_INT_STAT;
	wire hit_alm = paddr == OFS_ALARM;
	logic [CNT_NUM-1:0] hit_cnt;
	wire hit_any = hit_ctrl | hit_slot | hit_idle | hit_ins | hit_isr |
		hit_alm | (|hit_cnt);

	////////////////////////////////////////////////////////////////////
	// Frame position counters
	logic [POS_W-1:0] rx_pos_ff;
	logic [MFRM_W-1:0] rx_frm_ff;
	logic [POS_W-1:0] txs_pos_ff;
	logic [MFRM_W-1:0] txs_frm_ff;
	// Receive side: realigned by the receive sync pulse
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_pos_ff <= '0;
			rx_frm_ff <= '0;
		end
		else if (rx_stb)
		begin
			rx_pos_ff <= rx_sync_s ? '0 : rx_pos_ff + 1'b1;
			if (rx_sync_s || &rx_pos_ff)
				rx_frm_ff <= rx_frm_ff + 1'b1;
		end
	end
	// Transmit system side: frozen while payload loop owns the path
	wire txs_stb = txc_rise & ~plb; // RL6
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			txs_pos_ff <= '0;
			txs_frm_ff <= '0;
		end
		else if (txs_stb)
		begin
			txs_pos_ff <= tx_sync_s ? '0 : txs_pos_ff + 1'b1;
			if (tx_mfs_s)
				txs_frm_ff <= '0;
			else if (tx_sync_s || &txs_pos_ff)
				txs_frm_ff <= txs_frm_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit bit selection
	wire tx_stb = plb ? rx_stb : txc_rise; // RL5
	wire [POS_W-1:0] tx_pos = plb ? rx_pos_ff : txs_pos_ff;
	wire [MFRM_W-1:0] tx_frm = plb ? rx_frm_ff : txs_frm_ff;
	wire [SLOT_W-1:0] tx_slot = tx_pos[POS_W-1:3];
	wire [2:0] tx_bitn = tx_pos[2:0];
	wire tx_even = ~tx_frm[0];
	logic es_mem [FRAME_BITS];
	// Pin bits held one strobe so they line up with the position counters
	logic rx_bit_ff;
	logic [1:0] tx_bits_ff;
	wire es_rd = es_mem[rx_pos_ff];
	// Remote alarm toward far end hides while simulating
	wire rai_remote = (real_alarm[0] | real_alarm[2]) & ~sim; // RL14
	wire gen_ts0 = ~(plb & ctrl_ff.transparent_slot0_enable); // RL3 RL4
	wire in_ts0 = tx_slot == SLOT_FRAME;
	wire loop_hit = ctrl_ff.chan_loop_en & (tx_slot == loop_slot_ff);
	wire [2:0] fas_idx = 3'h7 - tx_bitn;
	wire [7:0] fas_ext = {1'b1, FAS_WORD};
	wire fas_bit = fas_ext[fas_idx];
	wire nfas_bit = (tx_bitn == 3'h2) ? rai_remote : 1'b1;
	wire frame_bit = (tx_bitn == 3'h0) ? 1'b1 : (tx_even ? fas_bit : nfas_bit);
	wire sys_bit = (!plb && ctrl_ff.cas_mode && tx_slot == SLOT_SIG) ?
		tx_bits_ff[1] : tx_bits_ff[0];
	wire src_bit = plb ? es_rd : sys_bit; // RL1 RL4
	wire gen_bit = (in_ts0 && gen_ts0) ? frame_bit : src_bit; // RL3
	wire idle_bit = idle_code_ff[fas_idx];
	wire tx_bit = loop_hit ? idle_bit : gen_bit; // RL12
	// Single defect placement points
	logic [INS_W-1:0] ins_at;
	assign ins_at[INS_FAS] = in_ts0 & gen_ts0 & tx_even & tx_bitn == 3'h1;
	assign ins_at[INS_MF] = in_ts0 & gen_ts0 & ~tx_even & tx_bitn == 3'h1;
	assign ins_at[INS_CRC] = in_ts0 & gen_ts0 & tx_even & tx_bitn == 3'h0;
	assign ins_at[INS_CAS] = tx_slot == SLOT_SIG & tx_frm == '0 &
		tx_bitn == 3'h0;
	assign ins_at[INS_PRBS] = tx_slot == SLOT_PRBS & tx_bitn == 3'h0;
	assign ins_at[INS_BPV] = 1'b1;
	wire [INS_W-1:0] ins_use = ins_pend_ff & ins_at & {INS_W{tx_stb}};
	wire flip = |ins_use[INS_PRBS:INS_FAS]; // RL20
	wire tx_line_bit = (tx_bit ^ flip) | ctrl_ff.transmit_ais_enable; // RL9
	logic tx_loop_ff;
	logic line_tx_ff;
	logic bpv_ff;
	// Line output: system stream passes in local loop, AIS forced
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_loop_ff <= 1'b0;
			line_tx_ff <= 1'b0;
			bpv_ff <= 1'b0;
		end
		else
		begin
			bpv_ff <= ins_use[INS_BPV]; // RL20
			if (tx_stb)
			begin
				tx_loop_ff <= tx_bit ^ flip; // RL9
				line_tx_ff <= tx_line_bit; // RL8
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive path, elastic store of one frame
	wire rx_in = ctrl_ff.local_loop_enable ? tx_loop_ff : rx_bit_ff; // RL7 RL10
	wire [SLOT_W-1:0] rx_slot = rx_pos_ff[POS_W-1:3];
	wire [2:0] rx_idx = 3'h7 - rx_pos_ff[2:0];
	logic [7:0] chan_buf_ff;
	logic rdo_ff;
	wire chan_out = ctrl_ff.chan_loop_en & (rx_slot == loop_slot_ff);
	wire rdo_bit = chan_out ? chan_buf_ff[rx_idx] :
		((plb & ctrl_ff.send_ais_to_system) | es_rd); // RL2 RL11
	// Store write and bit hold; plain data needs no reset
	always_ff @(posedge clk)
	begin
		if (rx_stb)
			es_mem[rx_pos_ff] <= rx_in; // RL1
		if (rx_stb)
			rx_bit_ff <= line_rx_s;
		if (txc_rise)
			tx_bits_ff <= {tx_sig_s, tx_data_s};
	end
	// Looped slot capture and system output
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			chan_buf_ff <= '0;
			rdo_ff <= 1'b0;
		end
		else
		begin
			if (txs_stb && loop_hit)
				chan_buf_ff[fas_idx] <= tx_bits_ff[0]; // RL11 RL13
			if (rx_stb)
				rdo_ff <= rdo_bit; // RL1
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alarm simulation
	logic [TICK_W-1:0] tick_ff;
	wire tick = sim & (tick_ff == TICK_W'(FRAME_CYCLES - 1));
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tick_ff <= '0;
		else if (!sim || tick)
			tick_ff <= '0;
		else
			tick_ff <= tick_ff + 1'b1;
	end
	// Live alarms follow the real alarm inputs as soon as simulation ends
	wire [ALM_W-1:0] alm_live = sim ? {ALM_W{1'b1}} : real_alarm; // RL14 RL18
	wire [SLIP_W-1:0] slip_ev = sim ? {SLIP_W{tick}} : real_slip; // RL15
	logic [CNT_NUM-1:0] cnt_app;
	assign cnt_app = {2'b11, ctrl_ff.crc4_mode, ctrl_ff.crc4_mode, 2'b11};
	wire [CNT_NUM-1:0] cnt_ev = sim ? ({CNT_NUM{tick}} & cnt_app) :
		real_err; // RL15 RL16 RL17
	wire [ISR_W-1:0] isr_set = {slip_ev, alm_live & ~alm_prev_ff}; // RL17
	wire isr_rd = rd_done & hit_isr;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			alm_prev_ff <= '0;
			isr_ff <= '0;
		end
		else
		begin
			alm_prev_ff <= alm_live;
			isr_ff <= (isr_ff & {ISR_W{~isr_rd}}) | isr_set; // RL18 RL19
		end
	end
	// Error counters, cleared by read, a same-cycle event survives
	genvar gi;
	generate
		for (gi = 0; gi < CNT_NUM; gi++)
		begin : g_cnt
			assign hit_cnt[gi] = paddr == OFS_CNT_BASE + APB_AW'(4 * gi);
			wire clr = rd_done & hit_cnt[gi];
			wire sat = &cnt_ff[gi];
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					cnt_ff[gi] <= '0;
				else if (clr)
					cnt_ff[gi] <= CNT_W'(cnt_ev[gi]); // RL19
				else if (cnt_ev[gi] && !sat)
					cnt_ff[gi] <= cnt_ff[gi] + 1'b1; // RL17
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// APB read data selection
	logic [APB_DW-1:0] cnt_rd;
	always_comb
	begin
		cnt_rd = '0;
		for (int i = 0; i < CNT_NUM; i++)
			if (hit_cnt[i])
				cnt_rd = APB_DW'(cnt_ff[i]);
	end
	wire [APB_DW-1:0] rd_data =
		hit_ctrl ? APB_DW'(ctrl_ff) :
		hit_slot ? APB_DW'(loop_slot_ff) :
		hit_idle ? APB_DW'(idle_code_ff) :
		hit_ins ? APB_DW'(ins_pend_ff) :
		hit_isr ? APB_DW'(isr_ff) :
		hit_alm ? APB_DW'(alm_live) : cnt_rd;
	// Ready and read data latched in the setup cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end
		else
		begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & ~hit_any;
			prdata_ff <= (apb_setup & ~pwrite) ? rd_data : '0;
		end
	end
	// Register writes; a new insertion request wins over its consumption
	wire [INS_W-1:0] ins_wr = (wr_done & hit_ins) ?
		pwdata[INS_W-1:0] : '0;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_ff <= CTRL_RST;
			loop_slot_ff <= '0;
			idle_code_ff <= '0;
			ins_pend_ff <= '0;
		end
		else
		begin
			if (wr_done && hit_ctrl)
				ctrl_ff <= ela_ctrl_t'(pwdata[CTRL_W-1:0]);
			if (wr_done && hit_slot)
				loop_slot_ff <= pwdata[SLOT_W-1:0]; // RL11
			if (wr_done && hit_idle)
				idle_code_ff <= pwdata[7:0];
			ins_pend_ff <= (ins_pend_ff & ~ins_use) | ins_wr; // RL21
		end
	end

	// Outputs from flip-flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign receive_system_data_out = rdo_ff;
	assign line_transmit_outputs = line_tx_ff;
	assign line_bpv_insert = bpv_ff;
endmodule

// File: test/ela_loop_test_sva.sv
`timescale 1ns/1ps
module ela_chk
	import ela_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ela_pkg::APB_AW-1:0] paddr,
	input wire logic [ela_pkg::APB_DW-1:0] pwdata,
	input wire logic [ela_pkg::APB_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Line coder request
	input wire logic line_bpv_insert
);
	import ela_pkg::*;
	logic sim_ff;
	logic nxt_sim;
	logic setup;
	logic done_wr;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////
	// Shadow of the simulation bit from completed control writes
	assign setup = psel && !penable;
	assign done_wr = psel && penable && pready && pwrite;
	assign nxt_sim = (done_wr && paddr == OFS_CTRL) ? pwdata[5] : sim_ff;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			sim_ff <= 1'b0;
		else
			sim_ff <= nxt_sim;
	////////////////////////////////////////////////////////////////////
	// Bus timing and refusal
	ready_after_setup_a: assert property (setup |=> pready)
		else $error("no ready after setup");
	ready_one_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	ready_cause_a: assert property (pready |-> $past(setup))
		else $error("ready without setup");
	rdata_idle_a: assert property (!pready |-> prdata == '0)
		else $error("read data outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	unmapped_err_a: assert property (setup && paddr > 8'h2c |=> pslverr)
		else $error("unmapped address accepted");
	mapped_ok_a: assert property (setup && paddr <= 8'h2c
		&& paddr[1:0] == 2'b00 |=> !pslverr)
		else $error("mapped address refused");
	// Simulation shows every alarm live
	sim_alarm_a: assert property (setup && !pwrite && paddr == OFS_ALARM
		&& sim_ff |=> prdata[3:0] == 4'hf)
		else $error("alarm not simulated");
	// One coder request per defect
	bpv_pulse_a: assert property ($rose(line_bpv_insert)
		|=> !line_bpv_insert)
		else $error("violation request too long");
endmodule
bind ela_loop_test ela_chk u_chk (.clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .line_bpv_insert);

// File: test/ela_pcm_model.sv
`timescale 1ns/1ps
module ela_pcm_model
	import ela_pkg::*;
#(
	parameter int HALF = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench control
	input wire logic tx_hold,
	// Receive side
	output logic receive_system_clock,
	output logic receive_sync_pulse,
	output logic line_receive_inputs,
	// Transmit side
	output logic transmit_system_clock,
	output logic transmit_system_data_in,
	output logic transmit_signaling_in,
	output logic transmit_sync_pulse,
	output logic transmit_multiframe_sync
);
	import ela_pkg::*;
	int ph_ff;
	logic [POS_W-1:0] pos_ff;
	logic [MFRM_W-1:0] frm_ff;
	////////////////////////////////////////////////////////////////////
	// Bit phase, frame position and multiframe count
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			ph_ff <= 0;
			pos_ff <= '0;
			frm_ff <= '0;
		end
		else if (ph_ff == 2 * HALF - 1)
		begin
			ph_ff <= 0;
			pos_ff <= pos_ff + 1'b1;
			if (pos_ff == 8'hff)
				frm_ff <= frm_ff + 1'b1;
		end
		else
			ph_ff <= ph_ff + 1;
	////////////////////////////////////////////////////////////////////
	// Clocks rise with each new bit; held transmit clock stands low
	assign receive_system_clock = ph_ff < HALF;
	assign transmit_system_clock = ph_ff < HALF && !tx_hold;
	assign receive_sync_pulse = pos_ff == 8'h00;
	assign transmit_sync_pulse = pos_ff == 8'h00;
	assign transmit_multiframe_sync = pos_ff == 8'h00 && frm_ff == 4'h0;
	// Same single rail code both ways; pattern repeats every frame
	assign line_receive_inputs = pos_ff[0] ^ pos_ff[3];
	assign transmit_system_data_in = pos_ff[1];
	assign transmit_signaling_in = pos_ff[4];
endmodule

// File: test/test_ela_loop_test.sv
`timescale 1ns/1ps
`define CHK(a, e) \
	begin \
		n_checks++; \
		if ((a) !== (e)) \
		begin \
			err_count++; \
			$display("MISMATCH %0t got %0h exp %0h", $time, (a), (e)); \
		end \
	end
module test_ela_loop_test;
	import ela_pkg::*;
	localparam int FB = 2048;
	// Bench signals
	logic clk, rst, psel, penable, pwrite, pready, pslverr, sl, tx_hold;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata, rdv;
	logic receive_system_clock, receive_sync_pulse, line_receive_inputs;
	logic transmit_system_clock, transmit_system_data_in;
	logic transmit_signaling_in, transmit_sync_pulse;
	logic transmit_multiframe_sync, receive_system_data_out;
	logic line_transmit_outputs, line_bpv_insert, lt_q;
	logic [ALM_W-1:0] real_alarm;
	logic [SLIP_W-1:0] real_slip;
	logic [CNT_NUM-1:0] real_err;
	int err_count, n_checks, tg, zl, zr, bpv_n, dt, dl, dr, m, i;
	bit cr;
	ela_loop_test #(.FRAME_CYCLES(20)) uut (.clk, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.receive_system_clock, .receive_sync_pulse, .receive_system_data_out,
		.transmit_system_clock, .transmit_system_data_in,
		.transmit_signaling_in, .transmit_sync_pulse,
		.transmit_multiframe_sync, .line_receive_inputs,
		.line_transmit_outputs, .line_bpv_insert, .real_alarm, .real_slip,
		.real_err);
	ela_pcm_model u_pcm (.clk, .rst, .tx_hold, .receive_system_clock,
		.receive_sync_pulse, .line_receive_inputs, .transmit_system_clock,
		.transmit_system_data_in, .transmit_signaling_in,
		.transmit_sync_pulse, .transmit_multiframe_sync);
	////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Output activity counters
	always @(posedge clk)
	begin
		lt_q <= line_transmit_outputs;
		if (line_transmit_outputs !== lt_q)
			tg++;
		if (line_transmit_outputs === 1'b0)
			zl++;
		if (receive_system_data_out === 1'b0)
			zr++;
		if (line_bpv_insert === 1'b1)
			bpv_n++;
	end
	////////////////////////////////////////////////////////////////////
	// One APB transfer, request held until ready is sampled
	task automatic ap(input logic w, input logic [APB_AW-1:0] a,
		input logic [APB_DW-1:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdv = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		ap(1'b1, a, d);
	endtask
	task automatic rdc(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] e);
		ap(1'b0, a, '0);
		`CHK(rdv, e)
	endtask
	// Activity seen over a span of cycles
	task automatic watch(input int n);
		int t0, l0, r0;
		t0 = tg;
		l0 = zl;
		r0 = zr;
		repeat (n) @(posedge clk);
		dt = tg - t0;
		dl = zl - l0;
		dr = zr - r0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Watchdog
	initial
	begin
		repeat (90000) @(posedge clk);
		err_count++;
		end_of_test();
	end
	// Tests
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, tx_hold} = '0;
		paddr = '0;
		pwdata = '0;
		{real_alarm, real_slip, real_err} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(OFS_CTRL, 32'h0);
		wr(OFS_LOOP_SLOT, 32'hff);
		rdc(OFS_LOOP_SLOT, 32'h1f);
		wr(OFS_IDLE_CODE, 32'ha5);
		rdc(OFS_IDLE_CODE, 32'ha5);
		ap(1'b0, 8'h40, '0);
		`CHK({sl, rdv}, {1'b1, 32'h0})
		ap(1'b0, OFS_INT_STAT, '0);
		$display("test registers done");
		for (m = 0; m < 2; m++)
		begin
			wr(OFS_CTRL, m ? 32'ha0 : 32'h20);
			{real_alarm, real_slip, real_err} <= '1;
			repeat (200) @(posedge clk);
			rdc(OFS_ALARM, 32'hf);
			{real_slip, real_err} <= '0;
			if (m)
				real_alarm <= 4'h0;
			wr(OFS_CTRL, 32'h0);
			rdc(OFS_ALARM, m ? 32'h0 : 32'hf);
			real_alarm <= 4'h0;
			rdc(OFS_INT_STAT, 32'h3f);
			rdc(OFS_INT_STAT, 32'h0);
			for (i = 0; i < CNT_NUM; i++)
			begin
				ap(1'b0, OFS_CNT_BASE + 8'(4 * i), '0);
				cr = (i == CNT_CRC4 || i == CNT_EBIT) && m == 0;
				`CHK(cr ? rdv == 0 : rdv >= 9 && rdv <= 12, 1'b1)
				rdc(OFS_CNT_BASE + 8'(4 * i), 32'h0);
			end
		end
		$display("test simulation done");
		wr(OFS_CTRL, 32'h180);
		wr(OFS_ERR_INS, 32'h3f);
		repeat (18 * FB) @(posedge clk);
		rdc(OFS_ERR_INS, 32'h0);
		wr(OFS_ERR_INS, 32'h20);
		repeat (100) @(posedge clk);
		`CHK(bpv_n, 2)
		$display("test insertion done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IDLE_CODE, 32'hff);
		watch(100);
		watch(2 * FB);
		m = dl;
		wr(OFS_CTRL, 32'h40);
		watch(100);
		watch(2 * FB);
		`CHK(m - dl, 64)
		$display("test slot loop done");
		tx_hold <= 1'b1;
		wr(OFS_CTRL, 32'h0);
		watch(100);
		watch(FB);
		`CHK(dt, 0)
		wr(OFS_CTRL, 32'h1);
		watch(100);
		watch(2 * FB);
		`CHK(dt > 50 && dr > 0, 1'b1)
		m = dl;
		wr(OFS_CTRL, 32'h5);
		watch(100);
		watch(2 * FB);
		`CHK(dl - m, 32)
		wr(OFS_CTRL, 32'h3);
		watch(100);
		watch(FB);
		`CHK({dt > 50, dr}, {1'b1, 32'h0})
		tx_hold <= 1'b0;
		wr(OFS_CTRL, 32'h18);
		watch(100);
		watch(FB);
		`CHK({dl, dr > 0}, {32'h0, 1'b1})
		$display("test loops done");
		end_of_test();
	end
endmodule
